/* File: hdl/flash_cmd_pkg.sv */
package flash_cmd_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam longint CLK_MHZ          = 50;
  localparam longint RST_TIME_NS      = 60000;     // Recovery after reset, idle array
  localparam longint RST_E_TIME_NS    = 30000000;  // Recovery after reset during erase
  localparam int     RST_CYCLES       = int'((RST_TIME_NS * CLK_MHZ + 999) / 1000);
  localparam int     RST_E_CYCLES     = int'((RST_E_TIME_NS * CLK_MHZ + 999) / 1000);
  localparam int     RST_CNT_W        = 21;

  // ----------------------------------------------------------------
  // Opcodes
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_SET_PARAM  = 8'hC0;
  localparam logic [7:0] OP_WRAP_READ  = 8'h0C;
  localparam logic [7:0] OP_QPI_ON     = 8'h38;
  localparam logic [7:0] OP_QPI_OFF    = 8'hFF;
  localparam logic [7:0] OP_RST_EN     = 8'h66;
  localparam logic [7:0] OP_RST        = 8'h99;
  localparam logic [7:0] OP_SFDP       = 8'h5A;
  localparam logic [7:0] OP_SET_WRAP   = 8'h77;

  // ----------------------------------------------------------------
  // Field positions, counts and reset values
  // ----------------------------------------------------------------
  localparam int         PARAM_DUMMY_LSB = 4;     // dummy_cycle_select in read_param_bits
  localparam int         PARAM_WRAP_LSB  = 0;     // wrap_length_select in read_param_bits
  localparam int         WRAP_BYTE_LSB   = 4;     // wrap_bits start in the wrap data byte
  localparam int         WRAP_LEN_LSB    = 1;     // Length code inside wrap_setting_bits
  localparam logic [1:0] ADDR_LAST       = 2'h2;  // Three address bytes
  localparam logic [1:0] WRAP_ARG_LAST   = 2'h3;  // Three filler bytes then wrap byte
  localparam logic [1:0] PARAM_ARG_LAST  = 2'h0;  // One parameter byte
  localparam logic [3:0] DUMMY_4         = 4'h4;
  localparam logic [3:0] DUMMY_6         = 4'h6;
  localparam logic [3:0] DUMMY_8         = 4'h8;
  localparam logic [3:0] SFDP_DUMMY      = 4'h8;
  localparam logic [23:0] WRAP_MASK_MAX  = 24'h00003F;  // 64-byte window
  localparam logic [7:0] READ_PARAM_RST  = 8'h00;
  localparam logic [2:0] WRAP_SET_RST    = 3'h0;
  localparam logic [7:0] CONT_RST        = 8'h00;
  localparam logic [7:0] SFDP_BLANK      = 8'hFF;
  localparam logic [4:0] SFDP_HDR_BYTES  = 5'h18;

  // Header bytes, least significant byte first
  localparam logic [63:0] SFDP_SIG_HDR   = 64'hFF01_0100_5044_4653;
  localparam logic [63:0] SFDP_HDR1      = 64'hFF00_0030_0901_0000;
  localparam logic [55:0] SFDP_HDR2_HI   = 56'hFF_0000_6003_0100;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [5:0] {
    ST_CMD   = 6'b000001,
    ST_ADDR  = 6'b000010,
    ST_DUMMY = 6'b000100,
    ST_DATA  = 6'b001000,
    ST_ARG   = 6'b010000,
    ST_IDLE  = 6'b100000
  } link_state_type;

  typedef enum logic [2:0] {
    EV_QPI_ON  = 3'h0,
    EV_QPI_OFF = 3'h1,
    EV_RESET   = 3'h2,
    EV_PARAM   = 3'h3,
    EV_WRAP    = 3'h4
  } event_code_type;

  typedef struct packed {
    logic       qpi;
    logic       busy;
    logic [1:0] dummy_sel;
    logic [1:0] wrap_sel;
  } link_cfg_type;

  typedef struct packed {
    event_code_type code;
    logic [7:0]     data;
  } link_event_type;

  function automatic logic [3:0] dummy_clocks(input logic [1:0] sel);
    case (sel)
      2'h2:    dummy_clocks = DUMMY_6;
      2'h3:    dummy_clocks = DUMMY_8;
      default: dummy_clocks = DUMMY_4;
    endcase
  endfunction

endpackage

/* File: hdl/flash_qpi_mode_reset_sfdp.sv */
`timescale 1ns/1ns
// Operation
// - QPI read-parameter command sets dummy and wrap
// - Dummy select codes give 4,4,6,8 clocks
// - Wrap select codes give 8,16,32,64 bytes
// - Wrap setting survives entry into QPI
// - Wrapped read stays inside its wrap window
// - Enable-QPI in SPI mode enters QPI
// - Disable-QPI in QPI mode returns to SPI
// - Mode switch keeps latch, suspend, wrap setting
// - Reset aborts and clears volatile settings
// - Reset commands accepted in both modes
// - Commands ignored during reset recovery time
// - Parameter read command served in both modes
// - Signature, revisions, header count at bytes 0-7
// - First parameter header at bytes 08H-0FH
// - Second parameter header at bytes 10H-17H
module flash_qpi_mode_reset_sfdp #(
  parameter logic [7:0] MAKER_ID      = 8'h5A,  // Arbitrary value
  parameter int         RST_E_CYC_PAR = flash_cmd_pkg::RST_E_CYCLES
) (
  input  wire logic        mclk_in,
  input  wire logic        resetn_in,
  input  wire logic        sclk_in,
  input  wire logic        cs_n_in,
  input  wire logic [3:0]  io_in,
  output logic      [3:0]  io_out_out,
  output logic      [3:0]  io_oe_n_out,
  output logic      [23:0] array_addr_out,
  input  wire logic [7:0]  array_data_in,
  input  wire logic        write_latch_set_in,
  input  wire logic        write_latch_clr_in,
  input  wire logic        suspend_set_in,
  input  wire logic        suspend_clr_in,
  input  wire logic        cont_load_in,
  input  wire logic [7:0]  cont_bits_in,
  input  wire logic        erase_active_in,
  output logic             qpi_mode_out,
  output logic      [7:0]  read_param_bits_out,
  output logic      [2:0]  wrap_setting_bits_out,
  output logic      [7:0]  continuous_read_bits_out,
  output logic             write_latch_flag_out,
  output logic             suspended_flag_out,
  output logic             reset_busy_out
);
  import flash_cmd_pkg::*;
  // ----------------------------------------------------------------
  // Link side declarations
  // ----------------------------------------------------------------
  logic           lrst_s1, lrst_s2;
  link_cfg_type   cfg_s1, cfg_s2, cfg_src;
  link_state_type st_r;
  logic [2:0]     cnt_r;
  logic [1:0]     bytes_r;
  logic [7:0]     sh_r, out_sh_r;
  logic [23:0]    addr_r;
  logic           sfdp_r, wrap_arg_r, rst_arm_r, ev_tg_r;
  logic [3:0]     dummy_left_r, io_out_r, io_oe_n_r;
  link_event_type ev_r;
  wire        qpi       = cfg_s2.qpi;
  wire [2:0]  last_cnt  = qpi ? 3'h1 : 3'h7;
  wire [7:0]  sh_nxt    = qpi ? {sh_r[3:0], io_in} : {sh_r[6:0], io_in[0]};
  wire        byte_done = (cnt_r == last_cnt);
  wire        accept    = (st_r == ST_CMD) && byte_done && !cfg_s2.busy;
  wire        op_on     = accept && (sh_nxt == OP_QPI_ON) && !qpi;
  wire        op_off    = accept && (sh_nxt == OP_QPI_OFF) && qpi;
  wire        op_rst_en = accept && (sh_nxt == OP_RST_EN);
  wire        op_rst    = accept && (sh_nxt == OP_RST) && rst_arm_r;
  wire        op_param  = accept && (sh_nxt == OP_SET_PARAM) && qpi;
  wire        op_wrap   = accept && (sh_nxt == OP_SET_WRAP) && !qpi;
  wire        op_wread  = accept && (sh_nxt == OP_WRAP_READ) && qpi;
  wire        op_sfdp   = accept && (sh_nxt == OP_SFDP);
  wire [1:0]  arg_last  = wrap_arg_r ? WRAP_ARG_LAST : PARAM_ARG_LAST;
  wire        arg_done  = (st_r == ST_ARG) && byte_done && (bytes_r == arg_last);
  wire        addr_done = (st_r == ST_ADDR) && byte_done && (bytes_r == ADDR_LAST);
  wire        ev_fire_l = op_on || op_off || op_rst || arg_done;
  wire        load      = ((st_r == ST_DUMMY) && (dummy_left_r == 4'h0)) ||
                          ((st_r == ST_DATA) && byte_done);
  wire [3:0]  dummy_need = sfdp_r ? SFDP_DUMMY : dummy_clocks(cfg_s2.dummy_sel);
  // Event code for the configuration side
  wire event_code_type ev_code_l = op_on  ? EV_QPI_ON  :
                                   op_off ? EV_QPI_OFF :
                                   op_rst ? EV_RESET   :
                                   wrap_arg_r ? EV_WRAP : EV_PARAM;
  // Wrap window and next read address
  wire [23:0] wrap_mask = WRAP_MASK_MAX >> (2'h3 - cfg_s2.wrap_sel);
  wire [23:0] addr_inc  = addr_r + 24'h000001;
  wire [23:0] addr_nxt  = sfdp_r ? addr_inc :
                          ((addr_r & ~wrap_mask) | (addr_inc & wrap_mask));
  // Parameter space: header then blank
  wire [191:0] sfdp_hdr  = {SFDP_HDR2_HI, MAKER_ID, SFDP_HDR1, SFDP_SIG_HDR};
  wire         sfdp_in   = (addr_r[23:5] == 19'h0) && (addr_r[4:0] < SFDP_HDR_BYTES);
  wire [7:0]   sfdp_byte = sfdp_in ? sfdp_hdr[{addr_r[4:0], 3'h0} +: 8] : SFDP_BLANK;
  wire [7:0]   byte_src  = sfdp_r ? sfdp_byte : array_data_in;
  // Next shift pattern and pin values for the data phase
  wire [7:0]  out_src   = load ? byte_src :
                          (qpi ? {out_sh_r[3:0], 4'h0} : {out_sh_r[6:0], 1'b0});
  wire [3:0]  io_src    = qpi ? out_src[7:4] : {2'h0, out_src[7], 1'b0};
  wire [3:0]  oe_src    = qpi ? 4'h0 : 4'hD;

  // ----------------------------------------------------------------
  // Link clock domain
  // ----------------------------------------------------------------
  // Reset and configuration synchronisers
  always_ff @(posedge sclk_in) begin
    lrst_s1 <= resetn_in;
    lrst_s2 <= lrst_s1;
    cfg_s1  <= cfg_src;
    cfg_s2  <= cfg_s1;
  end
  // Frame sequencer, cleared by chip select high
  always_ff @(posedge sclk_in or posedge cs_n_in) begin
    if (cs_n_in) begin
      st_r         <= ST_CMD;
      cnt_r        <= 3'h0;
      bytes_r      <= 2'h0;
      sh_r         <= 8'h00;
      addr_r       <= 24'h000000;
      sfdp_r       <= 1'b0;
      wrap_arg_r   <= 1'b0;
      dummy_left_r <= 4'h0;
      out_sh_r     <= 8'h00;
      io_out_r     <= 4'h0;
      io_oe_n_r    <= 4'hF;
    end else begin
      sh_r  <= sh_nxt;
      cnt_r <= byte_done ? 3'h0 : cnt_r + 3'h1;
      case (st_r)
        ST_CMD: begin
          bytes_r    <= 2'h0;
          sfdp_r     <= op_sfdp;
          wrap_arg_r <= op_wrap;
          if (op_wread || op_sfdp) begin
            st_r <= ST_ADDR;
          end else if (op_param || op_wrap) begin
            st_r <= ST_ARG;
          end else if (byte_done) begin
            st_r <= ST_IDLE;
          end
        end
        ST_ADDR: begin
          if (byte_done) begin
            addr_r  <= {addr_r[15:0], sh_nxt};
            bytes_r <= bytes_r + 2'h1;
          end
          if (addr_done) begin
            dummy_left_r <= dummy_need - 4'h1;
            st_r         <= ST_DUMMY;
          end
        end
        ST_DUMMY: begin
          dummy_left_r <= dummy_left_r - 4'h1;
          cnt_r        <= 3'h0;
          if (load) begin
            st_r <= ST_DATA;
          end
        end
        ST_ARG: begin
          if (byte_done) begin
            bytes_r <= bytes_r + 2'h1;
          end
          if (arg_done) begin
            st_r <= ST_IDLE;
          end
        end
        ST_DATA, ST_IDLE: begin
          st_r <= st_r;
        end
        default: begin
          st_r <= ST_IDLE;
        end
      endcase
      if (load) begin
        addr_r <= addr_nxt;
      end
      if (load || (st_r == ST_DATA)) begin
        out_sh_r  <= out_src;
        io_out_r  <= io_src;
        io_oe_n_r <= oe_src;
      end
    end
  end
  // Reset arming and event toggle, live across frames
  always_ff @(posedge sclk_in) begin
    if (!lrst_s2) begin
      rst_arm_r <= 1'b0;
      ev_tg_r   <= 1'b0;
      ev_r      <= '{code: EV_QPI_ON, data: 8'h00};
    end else begin
      if (accept) begin
        rst_arm_r <= op_rst_en;
      end
      if (ev_fire_l) begin
        ev_tg_r <= ~ev_tg_r;
        ev_r    <= '{code: ev_code_l, data: sh_nxt};
      end
    end
  end
  assign io_out_out     = io_out_r;
  assign io_oe_n_out    = io_oe_n_r;
  assign array_addr_out = addr_r;

  // ----------------------------------------------------------------
  // Configuration domain
  // ----------------------------------------------------------------
  logic                 tg_s1, tg_s2, tg_s3;
  logic                 qpi_r, wel_r, susp_r, busy_r;
  logic [7:0]           read_param_r, cont_r;
  logic [2:0]           wrap_set_r;
  logic [RST_CNT_W-1:0] rst_cnt_r;
  wire       ev_fire   = (tg_s2 ^ tg_s3) && !busy_r;
  wire       do_on     = ev_fire && (ev_r.code == EV_QPI_ON);
  wire       do_off    = ev_fire && (ev_r.code == EV_QPI_OFF);
  wire       do_reset  = ev_fire && (ev_r.code == EV_RESET);
  wire       do_param  = ev_fire && (ev_r.code == EV_PARAM);
  wire       do_wrap   = ev_fire && (ev_r.code == EV_WRAP);
  wire [RST_CNT_W-1:0] rst_load = erase_active_in ?
                                  RST_CNT_W'(RST_E_CYC_PAR - 1) :
                                  RST_CNT_W'(RST_CYCLES - 1);
  assign cfg_src = '{qpi: qpi_r, busy: busy_r,
                     dummy_sel: read_param_r[PARAM_DUMMY_LSB +: 2],
                     wrap_sel: wrap_set_r[WRAP_LEN_LSB +: 2]};
  // Event toggle synchroniser
  always_ff @(posedge mclk_in) begin
    if (!resetn_in) begin
      tg_s1 <= 1'b0;
      tg_s2 <= 1'b0;
      tg_s3 <= 1'b0;
    end else begin
      tg_s1 <= ev_tg_r;
      tg_s2 <= tg_s1;
      tg_s3 <= tg_s2;
    end
  end
  // Mode and read settings
  always_ff @(posedge mclk_in) begin
    if (!resetn_in || do_reset) begin
      qpi_r        <= 1'b0;
      read_param_r <= READ_PARAM_RST;
      wrap_set_r   <= WRAP_SET_RST;
      cont_r       <= CONT_RST;
    end else begin
      if (do_on) begin
        qpi_r <= 1'b1;
      end else if (do_off) begin
        qpi_r <= 1'b0;
      end
      if (do_param) begin
        read_param_r <= ev_r.data;
        wrap_set_r[WRAP_LEN_LSB +: 2] <= ev_r.data[PARAM_WRAP_LSB +: 2];
      end else if (do_wrap) begin
        wrap_set_r <= ev_r.data[WRAP_BYTE_LSB +: 3];
      end
      if (cont_load_in) begin
        cont_r <= cont_bits_in;
      end
    end
  end
  // Latch, suspend and reset recovery
  always_ff @(posedge mclk_in) begin
    if (!resetn_in) begin
      wel_r     <= 1'b0;
      susp_r    <= 1'b0;
      busy_r    <= 1'b0;
      rst_cnt_r <= '0;
    end else if (do_reset) begin
      wel_r     <= 1'b0;
      susp_r    <= 1'b0;
      busy_r    <= 1'b1;
      rst_cnt_r <= rst_load;
    end else begin
      wel_r  <= write_latch_set_in || (wel_r && !write_latch_clr_in);
      susp_r <= suspend_set_in || (susp_r && !suspend_clr_in);
      if (busy_r) begin
        rst_cnt_r <= rst_cnt_r - RST_CNT_W'(1);
        busy_r    <= (rst_cnt_r != '0);
      end
    end
  end
  assign qpi_mode_out             = qpi_r;
  assign read_param_bits_out      = read_param_r;
  assign wrap_setting_bits_out    = wrap_set_r;
  assign continuous_read_bits_out = cont_r;
  assign write_latch_flag_out     = wel_r;
  assign suspended_flag_out       = susp_r;
  assign reset_busy_out           = busy_r;

  // Recovery length seen by the checks, counted in helper logic
  logic [RST_CNT_W-1:0] busy_len_r;
  logic                 rst_long_r;
  always_ff @(posedge mclk_in) begin
    busy_len_r <= busy_r ? busy_len_r + RST_CNT_W'(1) : '0;
    rst_long_r <= do_reset ? erase_active_in : rst_long_r;
  end
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_qpi_enter: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    do_on |=> qpi_r) else $error("enable-QPI did not enter QPI");
  a_qpi_exit: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    do_off |=> !qpi_r ##1 !qpi_r) else $error("disable-QPI did not leave QPI");
  a_switch_keeps_wrap: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    (do_on || do_off) |=> $stable(wrap_set_r) && $stable(read_param_r))
    else $error("mode switch changed wrap setting");
  a_reset_clears: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    do_reset |=> !wel_r && !susp_r && !qpi_r && read_param_r == 8'h00 &&
                 wrap_set_r == 3'h0 && cont_r == 8'h00)
    else $error("reset left volatile state");
  a_reset_recovery: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    do_reset |=> busy_r [*8])
    else $error("reset recovery ended early");
  a_recovery_length: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    $fell(busy_r) |-> busy_len_r == (rst_long_r ? RST_CNT_W'(RST_E_CYC_PAR) :
                                                  RST_CNT_W'(RST_CYCLES)))
    else $error("reset recovery length wrong");
  a_param_dummy: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    do_param |=> read_param_r[5:4] == $past(ev_r.data[5:4]) &&
                 wrap_set_r[2:1] == $past(ev_r.data[1:0]))
    else $error("read parameters not stored");
  a_wrap_bits: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    do_wrap |=> wrap_set_r == $past(ev_r.data[6:4]))
    else $error("wrap bits not stored");
  a_wrap_window: assert property (@(posedge sclk_in) disable iff (cs_n_in)
    (load && !sfdp_r) |=> (addr_r & ~wrap_mask) == ($past(addr_r) & ~$past(wrap_mask)))
    else $error("wrapped read left its window");
  a_sfdp_signature: assert property (@(posedge sclk_in) disable iff (cs_n_in)
    (load && sfdp_r && addr_r == 24'h000000) |=> out_sh_r == 8'h53 ##0 addr_r == 24'h000001)
    else $error("signature byte wrong");
  a_qpi_four_lines: assert property (@(posedge sclk_in) disable iff (cs_n_in)
    (st_r == ST_DATA && qpi) |-> io_oe_n_r == 4'h0)
    else $error("QPI data not on four lines");
  c_qpi_enter:  cover property (@(posedge mclk_in) disable iff (!resetn_in) do_on);
  c_reset_done: cover property (@(posedge mclk_in) disable iff (!resetn_in) $fell(busy_r));
  c_sfdp_read:  cover property (@(posedge sclk_in) disable iff (cs_n_in) load && sfdp_r);
  c_wrap_read:  cover property (@(posedge sclk_in) disable iff (cs_n_in)
    load && !sfdp_r && ((addr_r & wrap_mask) == 24'h0));

endmodule // flash_qpi_mode_reset_sfdp

/* File: verification/flash_host_model.sv */
`timescale 1ns/1ns
// ----------------------------------------------------------------
// Host SPI/QPI controller model, serial clock 32 ns, idle low
// ----------------------------------------------------------------
module flash_host_model (
  output logic            sclk_out,
  output logic            cs_n_out,
  output logic      [3:0] io_out,
  input  wire logic [3:0] io_in
);
  bit         quad;
  logic [7:0] rx[$];

  // Idle bus: clock low, chip select high
  initial begin
    sclk_out = 1'b0;
    cs_n_out = 1'b1;
    io_out   = 4'hA;
    quad     = 1'b0;
  end

  // One clock pulse; data was set up just after the falling edge
  task automatic pulse();
    #16 sclk_out = 1'b1;
    #16 sclk_out = 1'b0;
  endtask

  // Edges with chip select high let settings cross, then a pause
  task automatic gap();
    repeat (3) pulse();
    #240;
  endtask

  // Byte out, MSB first; QPI sends the high nibble first
  task automatic put(input logic [7:0] b);
    if (quad) begin
      io_out = b[7:4];
      pulse();
      io_out = b[3:0];
      pulse();
    end else begin
      for (int i = 7; i >= 0; i--) begin
        io_out = {3'b111, b[i]};
        pulse();
      end
    end
  endtask

  // Byte in, sampled ahead of each rising edge
  task automatic get();
    logic [7:0] b;
    for (int i = 0; i < (quad ? 2 : 8); i++) begin
      b = quad ? {b[3:0], io_in} : {b[6:0], io_in[1]};
      pulse();
    end
    rx.push_back(b);
  endtask

  // One whole frame: opcode, argument bytes, dummies, read bytes
  task automatic frame(input logic [7:0] op, input logic [31:0] args, input int na,
                       input int nd, input int nr);
    rx.delete();
    cs_n_out = 1'b0;
    put(op);
    for (int i = na - 1; i >= 0; i--) put(args[8*i +: 8]);
    io_out = ~io_out;
    repeat (nd) pulse();
    for (int i = 0; i < nr; i++) get();
    #16 cs_n_out = 1'b1;
    gap();
  endtask
endmodule // flash_host_model

/* File: verification/tb.sv */
`timescale 1ns/1ns
module tb;
  import flash_cmd_pkg::*;
  localparam logic [7:0]   MAKER = 8'h3C;  // Arbitrary value
  localparam logic [199:0] SFDP_EXP = {8'hFF, 8'hFF, 8'h00, 8'h00, 8'h60, 8'h03,
    8'h01, 8'h00, MAKER, 64'hFF00_0030_0901_0000, 64'hFF01_0100_5044_4653};
  logic        mclk, resetn, sclk, cs_n, wl_set, sus_set, cont_load, erase;
  logic [3:0]  host_io, dev_io, oe_n, io_bus;
  logic [23:0] addr;
  logic [7:0]  rpb, crb, cont_bits, arr;
  logic [2:0]  wsb;
  logic        qpi_m, wlf, susf, busy;
  int          fail_count, compares;

  // ----------------------------------------------------------------
  // Wiring: device wins lines it enables, array byte from address
  // ----------------------------------------------------------------
  assign io_bus = (~oe_n & dev_io) | (oe_n & host_io);
  assign arr    = addr[7:0] ^ 8'hA5;

  flash_qpi_mode_reset_sfdp #(.MAKER_ID(MAKER), .RST_E_CYC_PAR(200)) flash_qpi_mode_reset_sfdp_i (
    .mclk_in(mclk), .resetn_in(resetn), .sclk_in(sclk), .cs_n_in(cs_n), .io_in(io_bus),
    .io_out_out(dev_io), .io_oe_n_out(oe_n), .array_addr_out(addr), .array_data_in(arr),
    .write_latch_set_in(wl_set), .write_latch_clr_in(1'b0), .suspend_set_in(sus_set),
    .suspend_clr_in(1'b0), .cont_load_in(cont_load), .cont_bits_in(cont_bits),
    .erase_active_in(erase), .qpi_mode_out(qpi_m), .read_param_bits_out(rpb),
    .wrap_setting_bits_out(wsb), .continuous_read_bits_out(crb),
    .write_latch_flag_out(wlf), .suspended_flag_out(susf), .reset_busy_out(busy));

  flash_host_model flash_host_model_i (
    .sclk_out(sclk), .cs_n_out(cs_n), .io_out(host_io), .io_in(io_bus));

  // Main clock, 20 ns
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic stop_test();
    if (fail_count == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic settle();
    repeat (12) @(negedge mclk);
  endtask

  task automatic cmd(input logic [7:0] op, input logic [31:0] a, input int na);
    flash_host_model_i.frame(op, a, na, 0, 0);
    settle();
  endtask

  // Wrapped read starting three bytes before the window end
  task automatic wrap_read(input int nd, input int len);
    logic [23:0] a0, a;
    a0 = 24'h012300 + 24'(len - 3);
    flash_host_model_i.frame(OP_WRAP_READ, {8'h00, a0}, 3, nd, 5);
    for (int i = 0; i < 5; i++) begin
      a = (a0 & ~24'(len - 1)) | ((a0 + 24'(i)) & 24'(len - 1));
      check("wrap_data", flash_host_model_i.rx[i], {24'h0, a[7:0] ^ 8'hA5});
    end
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_enter_qpi();
    @(negedge mclk);
    {wl_set, sus_set, cont_load} = 3'b111;
    @(negedge mclk);
    {wl_set, sus_set, cont_load} = 3'b000;
    cmd(OP_RST, 0, 0);
    check("lone_reset", busy, 1'b0);
    cmd(OP_QPI_ON, 0, 0);
    flash_host_model_i.quad = 1'b1;
    check("qpi_on", qpi_m, 1'b1);
    check("flags_kept_qpi", {wlf, susf, crb}, 10'h35C);
  endtask

  task automatic t_params();
    logic [7:0] p;
    for (int i = 0; i < 4; i++) begin
      p = {2'b00, 2'(i), 2'b00, 2'(i)};
      cmd(OP_SET_PARAM, {24'h0, p}, 1);
      check("read_param", rpb, p);
      wrap_read(i < 2 ? 4 : 2 * i + 2, 8 << i);
    end
  endtask

  task automatic t_leave_and_sfdp();
    cmd(OP_QPI_OFF, 0, 0);
    flash_host_model_i.quad = 1'b0;
    check("qpi_off", qpi_m, 1'b0);
    check("flags_kept_spi", {wlf, susf}, 2'b11);
    flash_host_model_i.frame(OP_SFDP, 0, 3, 8, 25);
    for (int i = 0; i < 25; i++) begin
      check("sfdp_spi", flash_host_model_i.rx[i], SFDP_EXP[8*i +: 8]);
    end
  endtask

  task automatic t_wrap_cmd();
    cmd(OP_SET_WRAP, 32'h0000_0040, 4);
    check("wrap_bits", wsb, 3'b100);
    cmd(OP_QPI_ON, 0, 0);
    flash_host_model_i.quad = 1'b1;
    check("wrap_kept", {qpi_m, wsb, wlf}, 5'b11001);
    wrap_read(8, 32);
    flash_host_model_i.frame(OP_SFDP, 32'h0E, 3, 8, 4);
    for (int i = 0; i < 4; i++) begin
      check("sfdp_qpi", flash_host_model_i.rx[i], SFDP_EXP[8*(i+14) +: 8]);
    end
  endtask

  task automatic t_reset();
    check("idle_before_reset", busy, 1'b0);
    cmd(OP_RST_EN, 0, 0);
    cmd(OP_RST, 0, 0);
    flash_host_model_i.quad = 1'b0;
    check("reset_busy", busy, 1'b1);
    check("cleared", {rpb, wsb, crb, wlf, susf, qpi_m}, 22'h0);
    cmd(OP_QPI_ON, 0, 0);
    check("busy_hold", busy, 1'b1);
    for (int i = 0; i < 300 && busy !== 1'b0; i++) @(negedge mclk);
    settle();
    check("ignored_in_recovery", {busy, qpi_m}, 2'b00);
    cmd(OP_QPI_ON, 0, 0);
    check("qpi_after_recovery", qpi_m, 1'b1);
    // Second reset with an idle array takes the idle recovery time
    flash_host_model_i.quad = 1'b1;
    erase = 1'b0;
    cmd(OP_RST_EN, 0, 0);
    cmd(OP_RST, 0, 0);
    flash_host_model_i.quad = 1'b0;
    repeat (2500) @(negedge mclk);
    check("idle_recovery_hold", busy, 1'b1);
    for (int i = 0; i < 600 && busy !== 1'b0; i++) @(negedge mclk);
    check("idle_recovery_end", busy, 1'b0);
  endtask

  // Reset, then the scenarios in order
  initial begin
    {resetn, wl_set, sus_set, cont_load} = 4'b0000;
    cont_bits = 8'h5C;
    erase = 1'b1;
    fail_count = 0;
    compares = 0;
    flash_host_model_i.gap();
    repeat (20) @(negedge mclk);
    resetn = 1'b1;
    flash_host_model_i.gap();
    settle();
    t_enter_qpi();
    t_params();
    t_leave_and_sfdp();
    t_wrap_cmd();
    t_reset();
    stop_test();
  end

  // Watchdog against a hang
  initial begin
    #500000;
    fail_count++;
    stop_test();
  end
endmodule // tb
